// *** arc_pkg.sv ***
// Constants, register map and types of the result computation unit
package arc_pkg;
   // Widths of the datapath
   localparam int RES_W = 10;
   localparam int ACC_W = 18;
   localparam int CNT_W = 8;
   localparam int THR_W = 16;
   localparam int ERR_W = 20;
   localparam int ST_W = 5;
   // Register byte addresses
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_REPEAT = 12'h004;
   localparam logic [11:0] A_SETPOINT = 12'h008;
   localparam logic [11:0] A_UPPER = 12'h00c;
   localparam logic [11:0] A_LOWER = 12'h010;
   localparam logic [11:0] A_RESULT = 12'h014;
   localparam logic [11:0] A_ACCUM = 12'h018;
   localparam logic [11:0] A_ERROR = 12'h01c;
   localparam logic [11:0] A_COUNT = 12'h020;
   localparam logic [11:0] A_STATUS = 12'h024;
   localparam logic [11:0] A_MASK = 12'h028;
   // Control register field positions
   localparam int F_MODE = 0;
   localparam int F_DSE = 3;
   localparam int F_CRS = 4;
   localparam int F_CALC = 8;
   localparam int F_TMD = 12;
   localparam int CTRL_W = 15;
   // Status bit positions
   localparam int S_DONE = 0;
   localparam int S_TIF = 1;
   localparam int S_OVF = 2;
   localparam int S_UTH = 3;
   localparam int S_LTH = 4;
   // Reset values
   localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0000;
   localparam logic [CNT_W-1:0] REPEAT_RST = 8'h01;
   localparam logic [ST_W-1:0] MASK_RST = 5'h00;
   // Computation modes
   typedef enum logic [2:0] {
      MD_BASIC = 3'h0, MD_ACCUM = 3'h1, MD_AVG = 3'h2,
      MD_BURST = 3'h3, MD_LPF = 3'h4
   } arc_mode_t;
   // Error calculation choices
   typedef enum logic [2:0] {
      CL_DERIV = 3'h0, CL_CVD = 3'h1, CL_RES_SP = 3'h2,
      CL_RES_FLT = 3'h3, CL_FLT_DERIV = 3'h4, CL_FLT_SP = 3'h5
   } arc_calc_t;
   // Threshold conditions
   typedef enum logic [2:0] {
      TM_NEVER = 3'h0, TM_BELOW_LO = 3'h1, TM_GE_LO = 3'h2,
      TM_INSIDE = 3'h3, TM_OUTSIDE = 3'h4, TM_LE_UP = 3'h5,
      TM_ABOVE_UP = 3'h6, TM_ALWAYS = 3'h7
   } arc_tmd_t;
   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_CONV = 2'b01, ST_CALC = 2'b10
   } arc_state_t;
endpackage : arc_pkg

// *** arc_sticky.sv ***
// Sticky flag bank with clear on demand; a set wins over a clear
`timescale 1ns/1ps
module arc_sticky #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] set,
   input wire logic clr,
   output logic [W-1:0] q
);
   // Flags hold until cleared, a new set in the clear cycle survives
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= (q & ~{W{clr}}) | set;
      end
   end
endmodule // arc_sticky

// *** arc_top.sv ***
// Post-conversion computation unit with APB registers and interrupt
// What this block does
// - Three-bit field picks one of five modes
// - Basic mode converts one or two samples
// - Accumulate adds each result, counts, flags each
// - Average tests at target, clears next trigger
// - Burst clears, retriggers until count reaches target
// - Filter every result, test from target on
// - Cutoff shift sets filter cutoff
// - Latch results, hold stable after conversion
// - Three-bit select picks the error calculation
// - Compare error with both thresholds, set flags
// - Three-bit field picks threshold condition
// - Met condition sets threshold interrupt flag
// - Comparisons are signed two's complement
// - Overflow flag signals threshold interrupt at every test
`timescale 1ns/1ps
module arc_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trigger,
   output logic conv_start,
   input wire logic conv_done,
   input wire logic [arc_pkg::RES_W-1:0] conv_result,
   output logic irq
);
   import arc_pkg::*;

   // Software settings
   logic [CTRL_W-1:0] ctrl_reg;
   logic [CNT_W-1:0] repeat_reg;
   logic [THR_W-1:0] setpoint_reg, upper_reg, lower_reg;
   logic [ST_W-1:0] mask_reg;
   // Decoded fields
   logic [2:0] computation_mode_select;
   logic double_sample_enable;
   logic [2:0] filter_cutoff_shift;
   logic [2:0] error_calc_select;
   logic [2:0] threshold_mode_select;
   arc_mode_t mode;
   // Datapath state
   arc_state_t state_reg;
   logic start_reg;
   logic [RES_W-1:0] result_reg, prev_result_reg, first_reg;
   logic second_reg;
   logic [ACC_W-1:0] acc_reg;
   logic [ACC_W-1:0] prev_filt_reg;
   logic [CNT_W-1:0] sample_count;
   logic tested_reg;
   logic [ERR_W-1:0] error_reg;
   // Status flags
   logic [ST_W-1:0] status;
   logic [ST_W-1:0] status_set;
   logic status_clr;
   // Combinational helpers
   logic [ACC_W:0] sum;
   logic [ACC_W-1:0] filt;
   logic [ERR_W-1:0] error_value;
   logic [ERR_W-1:0] up_ext, lo_ext;
   logic upper_threshold_flag, lower_threshold_flag;
   logic cond_met;
   logic test_now;
   logic more_burst;
   logic wr_en, rd_en;

   assign computation_mode_select = ctrl_reg[F_MODE +: 3];
   assign double_sample_enable = ctrl_reg[F_DSE];
   assign filter_cutoff_shift = ctrl_reg[F_CRS +: 3];
   assign error_calc_select = ctrl_reg[F_CALC +: 3];
   assign threshold_mode_select = ctrl_reg[F_TMD +: 3];

   always_comb begin
      unique case (computation_mode_select)
         MD_ACCUM: mode = MD_ACCUM;
         MD_AVG: mode = MD_AVG;
         MD_BURST: mode = MD_BURST;
         MD_LPF: mode = MD_LPF;
         default: mode = MD_BASIC;
      endcase
   end

   // Zero-wait APB slave
   assign pready = 1'b1;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;

   // Writable settings
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= CTRL_RST;
         repeat_reg <= REPEAT_RST;
         setpoint_reg <= '0;
         upper_reg <= '0;
         lower_reg <= '0;
         mask_reg <= MASK_RST;
      end else if (wr_en) begin
         unique case (paddr)
            A_CTRL: ctrl_reg <= pwdata[CTRL_W-1:0];
            A_REPEAT: repeat_reg <= pwdata[CNT_W-1:0];
            A_SETPOINT: setpoint_reg <= pwdata[THR_W-1:0];
            A_UPPER: upper_reg <= pwdata[THR_W-1:0];
            A_LOWER: lower_reg <= pwdata[THR_W-1:0];
            A_MASK: mask_reg <= pwdata[ST_W-1:0];
            default: ;
         endcase
      end
   end

   // Read mux and error answer for unmapped addresses
   always_comb begin
      prdata = 32'h0000_0000;
      pslverr = 1'b0;
      unique case (paddr)
         A_CTRL: prdata[CTRL_W-1:0] = ctrl_reg;
         A_REPEAT: prdata[CNT_W-1:0] = repeat_reg;
         A_SETPOINT: prdata[THR_W-1:0] = setpoint_reg;
         A_UPPER: prdata[THR_W-1:0] = upper_reg;
         A_LOWER: prdata[THR_W-1:0] = lower_reg;
         A_RESULT: prdata[RES_W-1:0] = result_reg;
         A_ACCUM: prdata[ACC_W-1:0] = acc_reg;
         A_ERROR: prdata = {{(32-ERR_W){error_reg[ERR_W-1]}}, error_reg};
         A_COUNT: prdata[CNT_W-1:0] = sample_count;
         A_STATUS: prdata[ST_W-1:0] = status;
         A_MASK: prdata[ST_W-1:0] = mask_reg;
         default: pslverr = psel & penable;
      endcase
   end

   // filtered value scaled by cutoff shift
   assign filt = acc_reg >> filter_cutoff_shift;

   // Next accumulator sum, overflow shows in the top bit
   always_comb begin
      sum = {1'b0, acc_reg} + {{(ACC_W+1-RES_W){1'b0}}, conv_result};
      if (mode == MD_LPF) begin
         sum = sum - {1'b0, filt};
      end
   end

   // Burst needs more samples; average, burst and filter test when the target is met, other modes test every result
   assign more_burst = (mode == MD_BURST) && (sample_count < repeat_reg);
   always_comb begin
      unique case (mode)
         MD_AVG, MD_BURST, MD_LPF: test_now = sample_count >= repeat_reg;
         default: test_now = 1'b1;
      endcase
   end

   always_comb begin
      unique case (error_calc_select)
         CL_DERIV: error_value = ERR_W'({1'b0, result_reg}) -
                                 ERR_W'({1'b0, prev_result_reg});
         CL_CVD: error_value = ERR_W'({1'b0, first_reg}) -
                               ERR_W'({1'b0, result_reg});
         CL_RES_SP: error_value = ERR_W'({1'b0, result_reg}) -
                                  ERR_W'($signed(setpoint_reg));
         CL_RES_FLT: error_value = ERR_W'({1'b0, result_reg}) -
                                   ERR_W'({1'b0, filt});
         CL_FLT_DERIV: error_value = ERR_W'({1'b0, filt}) -
                                     ERR_W'({1'b0, prev_filt_reg});
         CL_FLT_SP: error_value = ERR_W'({1'b0, filt}) -
                                  ERR_W'($signed(setpoint_reg));
         default: error_value = '0;
      endcase
   end

   assign up_ext = ERR_W'($signed(upper_reg));
   assign lo_ext = ERR_W'($signed(lower_reg));
   assign upper_threshold_flag = $signed(error_value) > $signed(up_ext);
   assign lower_threshold_flag = $signed(error_value) < $signed(lo_ext);

   always_comb begin
      unique case (threshold_mode_select)
         TM_NEVER: cond_met = 1'b0;
         TM_BELOW_LO: cond_met = lower_threshold_flag;
         TM_GE_LO: cond_met = ~lower_threshold_flag;
         TM_INSIDE: cond_met = ~lower_threshold_flag & ~upper_threshold_flag;
         TM_OUTSIDE: cond_met = lower_threshold_flag | upper_threshold_flag;
         TM_LE_UP: cond_met = ~upper_threshold_flag;
         TM_ABOVE_UP: cond_met = upper_threshold_flag;
         TM_ALWAYS: cond_met = 1'b1;
      endcase
   end

   // Sequencer: wait trigger, convert, compute
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         start_reg <= 1'b0;
         second_reg <= 1'b0;
      end else begin
         start_reg <= 1'b0;
         unique case (state_reg)
            ST_IDLE: if (trigger) begin
               state_reg <= ST_CONV;
               start_reg <= 1'b1;
            end
            ST_CONV: if (conv_done) begin
               if (mode == MD_BASIC && double_sample_enable && !second_reg)
               begin
                  second_reg <= 1'b1;
                  start_reg <= 1'b1;
               end else begin
                  second_reg <= 1'b0;
                  state_reg <= ST_CALC;
               end
            end
            ST_CALC: if (more_burst) begin
               state_reg <= ST_CONV;
               start_reg <= 1'b1;
            end else begin
               state_reg <= ST_IDLE;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
   assign conv_start = start_reg;

   // result latch and first sample of a pair
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         result_reg <= '0;
         first_reg <= '0;
      end else if (state_reg == ST_CONV && conv_done) begin
         result_reg <= conv_result;
         if (!second_reg) begin
            first_reg <= conv_result;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_reg <= '0;
         sample_count <= '0;
         tested_reg <= 1'b0;
      end else if (state_reg == ST_IDLE && trigger &&
                   (mode == MD_BURST || (mode == MD_AVG && tested_reg))) begin
         acc_reg <= '0;
         sample_count <= '0;
         tested_reg <= 1'b0;
      end else if (state_reg == ST_CONV && conv_done) begin
         if (mode == MD_BASIC) begin
            acc_reg <= ACC_W'(conv_result);
         end else begin
            acc_reg <= sum[ACC_W-1:0];
            if (sample_count != '1) begin
               sample_count <= sample_count + 1'b1;
            end
         end
      end else if (state_reg == ST_CALC) begin
         tested_reg <= test_now && !more_burst;
      end
   end

   // Previous values for derivative calculations, error snapshot
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev_result_reg <= '0;
         prev_filt_reg <= '0;
         error_reg <= '0;
      end else if (state_reg == ST_CALC) begin
         prev_result_reg <= result_reg;
         if (test_now) begin
            prev_filt_reg <= filt;
            error_reg <= error_value;
         end
      end
   end

   // Status events
   always_comb begin
      status_set = '0;
      // Overflow of the accumulator
      status_set[S_OVF] = state_reg == ST_CONV && conv_done &&
                          mode != MD_BASIC && sum[ACC_W];
      if (state_reg == ST_CALC) begin
         status_set[S_DONE] = ~more_burst;
         if (test_now && !more_burst) begin
            status_set[S_UTH] = upper_threshold_flag;
            status_set[S_LTH] = lower_threshold_flag;
            status_set[S_TIF] = cond_met | status[S_OVF];
         end
      end
   end
   assign status_clr = rd_en && paddr == A_STATUS;

   // Sticky status, a read clears it
   arc_sticky #(.W(ST_W)) u_status (
      .clk(clk),
      .rst(rst),
      .set(status_set),
      .clr(status_clr),
      .q(status)
   );

   // Level interrupt from unmasked flags
   assign irq = |(status & mask_reg);

   // Checks
   sequence s_calc_test;
      state_reg == ST_CALC && test_now && !more_burst;
   endsequence
   sequence s_acc_sample;
      state_reg == ST_CONV && conv_done && mode == MD_ACCUM && !sum[ACC_W];
   endsequence

   a_trig_start: assert property (@(posedge clk) disable iff (rst)
      state_reg == ST_IDLE && trigger |=> conv_start && state_reg == ST_CONV)
      else $error("trigger did not start a conversion");
   a_double_pair: assert property (@(posedge clk) disable iff (rst)
      state_reg == ST_CONV && conv_done && mode == MD_BASIC &&
      double_sample_enable && !second_reg |=> conv_start && !status_set[S_DONE])
      else $error("second sample not requested");
   a_acc_add: assert property (@(posedge clk) disable iff (rst)
      s_acc_sample |=> acc_reg == $past(acc_reg) + ACC_W'($past(conv_result)))
      else $error("accumulator did not add the result");
   a_avg_clear: assert property (@(posedge clk) disable iff (rst)
      state_reg == ST_IDLE && trigger && mode == MD_AVG && tested_reg
      |=> sample_count == '0 && acc_reg == '0)
      else $error("average did not clear after test");
   a_burst_retrig: assert property (@(posedge clk) disable iff (rst)
      state_reg == ST_CALC && more_burst |=> conv_start ##1 state_reg == ST_CONV)
      else $error("burst did not retrigger");
   a_result_hold: assert property (@(posedge clk) disable iff (rst)
      !(state_reg == ST_CONV && conv_done) |=> $stable(result_reg))
      else $error("result changed without a conversion");
   a_ovf_tif: assert property (@(posedge clk) disable iff (rst)
      s_calc_test and status[S_OVF] |=> status[S_TIF])
      else $error("overflow did not raise threshold flag");
   a_never_quiet: assert property (@(posedge clk) disable iff (rst)
      state_reg == ST_CALC && threshold_mode_select == TM_NEVER &&
      !status[S_OVF] |-> !status_set[S_TIF])
      else $error("never condition raised threshold flag");
   a_upper_flag: assert property (@(posedge clk) disable iff (rst)
      s_calc_test and $signed(error_value) > $signed(up_ext)
      |=> status[S_UTH] ##0 error_reg == $past(error_value))
      else $error("upper flag missing");
   a_outside_tif: assert property (@(posedge clk) disable iff (rst)
      s_calc_test and threshold_mode_select == TM_OUTSIDE &&
      (upper_threshold_flag || lower_threshold_flag) |=> status[S_TIF])
      else $error("outside condition did not set flag");
endmodule // arc_top

// *** arc_conv_model.sv ***
// Behavioural converter core that answers conversion requests
`timescale 1ns/1ps
module arc_conv_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic conv_start,
   output logic conv_done,
   output logic [arc_pkg::RES_W-1:0] conv_result
);
   import arc_pkg::*;
   int q[$]; // Results still to deliver
   int dly = 1; // Cycles from request to answer
   int left; // Cycles remaining
   bit busy; // Conversion in progress
   logic [RES_W-1:0] last; // Last delivered result
   // Answer each request after a set delay
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         conv_done <= 1'b0;
         busy <= 1'b0;
         last <= '0;
         conv_result <= '0;
      end else begin
         conv_done <= 1'b0;
         // Idle line never keeps the old value
         conv_result <= ~last;
         if (conv_start) begin
            busy <= 1'b1;
            left <= dly;
         end else if (busy && left > 1) begin
            left <= left - 1;
         end else if (busy) begin
            busy <= 1'b0;
            conv_done <= 1'b1;
            conv_result <= RES_W'(q[0]);
            last <= RES_W'(q[0]);
            void'(q.pop_front());
         end
      end
   end
endmodule // arc_conv_model

// *** tb.sv ***
// Self-checking bench of the result computation unit
`timescale 1ns/1ps
module tb;
   import arc_pkg::*;
   logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, trigger = 0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, conv_start, conv_done, irq, perr;
   logic [RES_W-1:0] conv_result;
   int errors = 0, compares = 0, nstart = 0;
   // Reference model state
   int acc, cnt, prv, pflt, sp, up, lo, rpt, shf, cl, tm, md, ovs;
   int clrp, msk, quiet;
   int rq[$];
   // Clock of 10 ns
   always #5 clk = ~clk;
   // Count conversion requests
   always @(posedge clk) if (conv_start === 1'b1) nstart++;
   arc_top i_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .trigger(trigger),
      .conv_start(conv_start), .conv_done(conv_done),
      .conv_result(conv_result), .irq(irq));
   arc_conv_model i_conv (.clk(clk), .rst(rst), .conv_start(conv_start),
      .conv_done(conv_done), .conv_result(conv_result));
   task automatic print_verdict();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask
   // One APB transfer, held until pready
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      int k;
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      perr = pslverr;
      if (k >= 20) begin
         errors++;
         print_verdict();
      end
      psel <= 0;
      penable <= 0;
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 0);
      chk(rd, e);
   endtask
   task automatic cfg(input int m, dse, s, c, t);
      apb(1, A_CTRL, m | dse << 3 | s << 4 | c << 8 | t << 12);
      md = (m > 4) ? 0 : m;
      shf = s;
      cl = c;
      tm = t;
   endtask
   task automatic reset_all();
      rst <= 1;
      repeat (6) @(posedge clk);
      rst <= 0;
      {acc, cnt, prv, pflt, ovs, clrp, sp, up, lo, msk} = '0;
      rpt = 1;
   endtask
   // Run one trigger and compare with the model
   task automatic fire(input int n);
      int k, r, tst, flt, e, hit, uth, lth, q[$];
      logic [4:0] st;
      q = rq;
      rq = {};
      foreach (q[i]) i_conv.q.push_back(q[i]);
      i_conv.dly = $urandom_range(1, 4);
      nstart = 0;
      @(posedge clk) trigger <= 1;
      @(posedge clk) trigger <= 0;
      k = 0;
      while (i_conv.q.size() > 0 && k < 200) begin
         @(negedge clk);
         k++;
      end
      if (k >= 200) begin
         errors++;
         print_verdict();
      end
      repeat (3) @(negedge clk);
      if ((md == 3) || (md == 2 && clrp)) {acc, cnt, clrp} = '0;
      foreach (q[i]) begin
         // Basic mode keeps only the latest result and no count
         if (md == 0) acc = q[i];
         else if (md == 4) acc = acc + q[i] - (acc >> shf);
         else acc = acc + q[i];
         if (acc > 32'h3ffff) ovs = 1;
         acc &= 32'h3ffff;
         if (md > 0 && cnt < 255) cnt++;
      end
      r = q[$];
      flt = acc >> shf;
      tst = (md < 2) ? 1 : (cnt >= rpt);
      case (cl)
         0: e = r - prv;
         1: e = q[0] - q[$];
         2: e = r - sp;
         3: e = r - flt;
         4: e = flt - pflt;
         default: e = flt - sp;
      endcase
      prv = r;
      if (tst) pflt = flt;
      if (md == 2 && tst) clrp = 1;
      uth = tst && e > up;
      lth = tst && e < lo;
      case (tm)
         1: hit = lth;
         2: hit = !lth;
         3: hit = !lth && !uth;
         4: hit = lth || uth;
         5: hit = !uth;
         6: hit = uth;
         7: hit = 1;
         default: hit = 0;
      endcase
      hit = tst && (hit || ovs);
      st = {lth[0], uth[0], ovs[0], hit[0], 1'b1};
      // Overflow stays flagged until the status is read
      if (quiet) return;
      ovs = 0;
      chk(nstart, (md == 3) ? rpt : n);
      chk(irq, |(st & msk[4:0]));
      rdchk(A_STATUS, st);
      // Let the clear of the status read settle
      @(negedge clk);
      chk(irq, 0);
      if (tst) rdchk(A_ERROR, e);
      if (md > 0) rdchk(A_ACCUM, acc);
      if (md > 0) rdchk(A_COUNT, cnt);
      if (n == 1 || md == 3) rdchk(A_RESULT, r);
   endtask
   initial begin
      int evs[5] = '{-17, -16, 0, 16, 17};
      void'($urandom(32'hbf762eb8));
      reset_all();
      rdchk(A_CTRL, 0);
      rdchk(A_REPEAT, 1);
      rdchk(A_MASK, 0);
      apb(1, 12'h0fc, 32'h1);
      chk(perr, 1);
      // Signed window checks, unused mode codes act basic
      up = 16;
      lo = -16;
      msk = 2;
      apb(1, A_UPPER, 32'h0010);
      apb(1, A_LOWER, 32'hfff0);
      apb(1, A_MASK, 32'h2);
      for (int t = 0; t < 8; t++) begin
         foreach (evs[i]) begin
            cfg((t % 2) ? 5 + t % 3 : 0, 0, 0, 2, t);
            sp = 100 - evs[i];
            apb(1, A_SETPOINT, sp & 16'hffff);
            rq = {100};
            fire(1);
         end
      end
      cfg(0, 1, 0, 1, 7);
      rq = {700, 300};
      fire(2);
      rq = {300, 700};
      fire(2);
      // Accumulate with every calculation except CL_CVD
      reset_all();
      for (int c = 0; c < 6; c++) begin
         if (c == 1) continue;
         cfg(1, 0, 2, c, $urandom_range(0, 7));
         sp = $urandom_range(0, 1023);
         apb(1, A_SETPOINT, sp);
         repeat (2) begin
            rq = {$urandom_range(0, 1023)};
            fire(1);
         end
      end
      // Average, burst and filter with a repeat target
      for (int m = 2; m < 5; m++) begin
         reset_all();
         rpt = m + 1;
         apb(1, A_REPEAT, rpt);
         cfg(m, 0, m - 1, m + 1, m + 2);
         repeat (7) begin
            rq = {$urandom_range(0, 1023)};
            if (m == 3) repeat (rpt - 1) rq.push_back($urandom_range(0, 1023));
            fire(rq.size());
         end
      end
      // Accumulator overflow forces the threshold interrupt
      reset_all();
      cfg(1, 0, 0, 2, 0);
      quiet = 1;
      repeat (257) begin
         rq = {1023};
         fire(1);
      end
      quiet = 0;
      rq = {1023};
      fire(1);
      apb(1, A_COUNT, 32'h55);
      rdchk(A_COUNT, cnt);
      print_verdict();
   end
   // Cut a hung run short
   initial begin
      #1000000;
      errors++;
      print_verdict();
   end
endmodule // tb
